// ==== hdl/passive_serial_config_sequence.sv ====
`timescale 1ns/10ps

module passive_serial_config_sequence
    import cfg_loader_pkg::*;
#(
    parameter int STATUS_HOLD   = STATUS_HOLD_CYC,
    parameter int INIT_OSC      = INIT_OSC_CYC,
    parameter int USER_PERIODS  = USER_INIT_PERIODS,
    parameter int BITSTREAM_LEN = BITSTREAM_BYTES_DFLT
)
(
    // Core clock and synchronous reset.
    input  logic      clk,
    input  logic      sys_rst,
    // Configuration request and open-drain status pin.
    input  logic      config_request_n,
    input  logic      cfg_state_flag_n_in,
    output logic      cfg_state_flag_n_out,
    output logic      cfg_state_flag_n_oe,
    // Serial link, clocked by the host.
    input  logic      serial_load_clock,
    input  logic      serial_data,
    // Sequence outputs.
    output logic      load_complete,
    output logic      user_mode,
    // User start-up clock option.
    input  logic      user_clock_option,
    input  logic      user_init_clock,
    output logic      user_init_clock_enable,
    // Received configuration bytes.
    output cfg_word_s cfg_word,
    output logic      cfg_word_valid,
    input  logic      cfg_word_ready
);

    cfg_state_e              state_reg;        // Sequence state.
    cfg_state_e              state_next;       // Next sequence state.
    logic [TIMER_W-1:0]      timer_reg;        // Shared interval counter.
    logic [TIMER_W-1:0]      timer_next;       // Next interval count.
    logic                    uclk_en_reg;      // User start-up clock is enabled.
    logic                    uclk_en_next;     // Next user clock enable.
    logic [BYTE_CNT_W-1:0]   byte_cnt_reg;     // Bytes accepted in this load.
    logic                    stat_oe_reg;      // Status pin pulled low.
    logic                    done_reg;         // Load complete level.
    logic                    user_reg;         // User mode level.
    logic                    link_clear_reg;   // Holds link logic cleared outside a load.
    logic [BIT_CNT_W-1:0]    bit_cnt_reg;      // Link-side bit position.
    logic [BYTE_W-1:0]       shift_reg;        // Link-side shift register.
    logic [BYTE_W-1:0]       byte_hold_reg;    // Link-side completed byte.
    logic                    link_toggle_reg;  // Flips once per completed byte.
    logic [SYNC_COUNT-1:0]   sync_raw;         // Inputs from outside the core domain.
    logic [SYNC_COUNT-1:0]   filt;             // Settled synchronised levels.
    logic [SYNC_COUNT-1:0]   filt_d_reg;       // Settled levels one cycle ago.
    logic                    req_high;         // Request pin released.
    logic                    byte_event;       // A byte completed on the link.
    logic                    uclk_rise;        // Rising edge of the user clock.
    logic                    word_push;        // Byte offered to the buffer.
    logic                    buf_ready;        // Buffer can take a byte.
    logic                    overrun;          // Byte arrived with the buffer full.
    logic                    buf_clear;        // Empties the buffer on a new request.
    cfg_word_s               push_word;        // Byte with its end mark.

    // Link logic: shifts in data on each serial clock rise, low bit first.
    always_ff @(posedge serial_load_clock or posedge link_clear_reg)
    begin
        if (link_clear_reg)
        begin
            bit_cnt_reg     <= '0;
            shift_reg       <= '0;
            byte_hold_reg   <= '0;
            link_toggle_reg <= 1'b0;
        end
        else
        begin
            shift_reg   <= {serial_data, shift_reg[BYTE_W-1:1]};
            bit_cnt_reg <= bit_cnt_reg + BIT_CNT_W'(1);
            // The byte is held stable for a full byte time while the toggle crosses.
            if (bit_cnt_reg == BIT_LAST)
            begin
                byte_hold_reg   <= {serial_data, shift_reg[BYTE_W-1:1]};
                link_toggle_reg <= ~link_toggle_reg;
            end
        end
    end

    // Three-stage synchronisers; a level counts once stages two and three agree.
    assign sync_raw = {link_toggle_reg, user_init_clock, cfg_state_flag_n_in, config_request_n};

    generate
        for (genvar g = 0; g < SYNC_COUNT; g++)
        begin : g_sync
            logic [2:0] stage_reg; // Stage 0 feeds only stage 1.
            logic       level_reg; // Agreed level.

            // Shift the raw input through the chain.
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    stage_reg <= {3{SYNC_INIT[g]}};
                end
                else
                begin
                    stage_reg <= {stage_reg[1:0], sync_raw[g]};
                end
            end

            // Accept a new level only when the last two stages agree.
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    level_reg <= SYNC_INIT[g];
                end
                else if (stage_reg[1] == stage_reg[2])
                begin
                    level_reg <= stage_reg[2];
                end
            end

            assign filt[g] = level_reg;
        end
    endgenerate

    // Delayed copies of the settled levels for edge detection.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            filt_d_reg <= SYNC_INIT;
        end
        else
        begin
            filt_d_reg <= filt;
        end
    end

    assign req_high   = filt[SYNC_REQ];
    assign byte_event = filt[SYNC_TOG] ^ filt_d_reg[SYNC_TOG];
    assign uclk_rise  = filt[SYNC_UCLK] & ~filt_d_reg[SYNC_UCLK];

    // Bytes are taken only during a load and only up to the bitstream length.
    assign word_push      = byte_event && (state_reg == ST_LOAD)
                            && (byte_cnt_reg != BYTE_CNT_W'(BITSTREAM_LEN));
    assign overrun        = word_push && !buf_ready;
    assign push_word.data = byte_hold_reg;
    assign push_word.last = (byte_cnt_reg == BYTE_CNT_W'(BITSTREAM_LEN - 1));
    assign buf_clear      = sys_rst || (state_reg == ST_RESET);

    // Two-entry buffer between the link and the byte consumer.
    word_pair_buffer u_buffer (
        .clk       (clk),
        .sys_rst   (buf_clear),
        .in_valid  (word_push),
        .in_ready  (buf_ready),
        .in_word   (push_word),
        .out_valid (cfg_word_valid),
        .out_ready (cfg_word_ready),
        .out_word  (cfg_word)
    );

    // Counts accepted bytes; a new request starts the count again.
    always_ff @(posedge clk)
    begin
        if (buf_clear)
        begin
            byte_cnt_reg <= '0;
        end
        else if (word_push && buf_ready)
        begin
            byte_cnt_reg <= byte_cnt_reg + BYTE_CNT_W'(1);
        end
    end

    // Next state, interval counter and user clock enable.
    always_comb
    begin
        state_next   = state_reg;
        timer_next   = timer_reg;
        uclk_en_next = uclk_en_reg;
        case (state_reg)
            ST_RESET:
            begin
                // Status stays low for the full hold time and until the request is released.
                if (timer_reg != TIMER_W'(STATUS_HOLD - 1))
                begin
                    timer_next = timer_reg + TIMER_W'(1);
                end
                else if (req_high)
                begin
                    state_next = ST_WAIT_STAT;
                    timer_next = '0;
                end
            end
            ST_WAIT_STAT:
            begin
                // An outside party may still hold the status pin low.
                if (filt[SYNC_STAT])
                begin
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                // A lost byte fails the load; a full, drained bitstream completes it.
                if (overrun)
                begin
                    state_next = ST_ERROR;
                end
                else if ((byte_cnt_reg == BYTE_CNT_W'(BITSTREAM_LEN)) && !cfg_word_valid)
                begin
                    state_next = ST_INIT;
                    timer_next = '0;
                end
            end
            ST_INIT:
            begin
                if (!user_clock_option)
                begin
                    // Internal timer sets the initialisation interval.
                    if (timer_reg == TIMER_W'(INIT_OSC - 1))
                    begin
                        state_next = ST_USER;
                    end
                    else
                    begin
                        timer_next = timer_reg + TIMER_W'(1);
                    end
                end
                else if (!uclk_en_reg)
                begin
                    // Wait out the delay before enabling the user clock.
                    if (timer_reg == TIMER_W'(UCLK_DELAY_CYC - 1))
                    begin
                        uclk_en_next = 1'b1;
                        timer_next   = '0;
                    end
                    else
                    begin
                        timer_next = timer_reg + TIMER_W'(1);
                    end
                end
                else if (uclk_rise)
                begin
                    // Count user clock periods; a missed edge only lengthens the wait.
                    // The first rise only opens the first period, because its edge may predate the enable.
                    if (timer_reg == TIMER_W'(USER_PERIODS))
                    begin
                        state_next = ST_USER;
                    end
                    else
                    begin
                        timer_next = timer_reg + TIMER_W'(1);
                    end
                end
            end
            ST_USER:
            begin
                state_next = ST_USER;
            end
            ST_ERROR:
            begin
                state_next = ST_ERROR;
            end
            default:
            begin
                state_next = ST_RESET;
            end
        endcase
        // A request from any other state restarts configuration.
        if (!req_high && (state_reg != ST_RESET))
        begin
            state_next = ST_RESET;
            timer_next = '0;
        end
        if (state_next != ST_INIT)
        begin
            uclk_en_next = 1'b0;
        end
    end

    // Sequence state and counters.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg   <= ST_RESET;
            timer_reg   <= '0;
            uclk_en_reg <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            timer_reg   <= timer_next;
            uclk_en_reg <= uclk_en_next;
        end
    end

    // Pin levels follow the state they enter with it.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stat_oe_reg    <= 1'b1;
            done_reg       <= 1'b0;
            user_reg       <= 1'b0;
            link_clear_reg <= 1'b1;
        end
        else
        begin
            stat_oe_reg    <= (state_next == ST_RESET) || (state_next == ST_ERROR);
            done_reg       <= (state_next == ST_INIT) || (state_next == ST_USER);
            user_reg       <= (state_next == ST_USER);
            link_clear_reg <= (state_next != ST_LOAD);
        end
    end

    // Status is open drain: only a low level is ever driven.
    always_ff @(posedge clk)
    begin
        cfg_state_flag_n_out <= 1'b0;
    end

    assign cfg_state_flag_n_oe    = stat_oe_reg;
    assign load_complete          = done_reg;
    assign user_mode              = user_reg;
    assign user_init_clock_enable = uclk_en_reg;

endmodule

// ==== hdl/word_pair_buffer.sv ====
`timescale 1ns/10ps

module word_pair_buffer
    import cfg_loader_pkg::*;
(
    // Clock and synchronous clear.
    input  logic      clk,
    input  logic      sys_rst,
    // Filling side.
    input  logic      in_valid,
    output logic      in_ready,
    input  cfg_word_s in_word,
    // Draining side.
    output logic      out_valid,
    input  logic      out_ready,
    output cfg_word_s out_word
);

    cfg_word_s head_reg;    // Oldest word, shown on the output.
    cfg_word_s spare_reg;   // Second word, held while the head stalls.
    logic      head_v_reg;  // Head entry holds a word.
    logic      spare_v_reg; // Spare entry holds a word.
    logic      push;        // A word enters this cycle.
    logic      pop;         // A word leaves this cycle.

    // The buffer takes a word while the spare entry is free.
    assign in_ready  = ~spare_v_reg;
    assign push      = in_valid & in_ready;
    assign pop       = head_v_reg & out_ready;
    assign out_valid = head_v_reg;
    assign out_word  = head_reg;

    // Occupancy flags move with pushes and pops.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            head_v_reg  <= 1'b0;
            spare_v_reg <= 1'b0;
        end
        else if (pop)
        begin
            // The spare moves up, or the new word lands in its place.
            head_v_reg  <= spare_v_reg | push;
            spare_v_reg <= spare_v_reg & push;
        end
        else if (push)
        begin
            // A new word fills the head first, then the spare.
            head_v_reg  <= 1'b1;
            spare_v_reg <= head_v_reg;
        end
    end

    // Data entries follow the same moves as the flags.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            head_reg  <= '0;
            spare_reg <= '0;
        end
        else if (pop)
        begin
            // The head takes the spare, or the incoming word when the spare is empty.
            head_reg <= spare_v_reg ? spare_reg : in_word;
        end
        else if (push)
        begin
            // The word goes to whichever entry is free.
            if (head_v_reg)
            begin
                spare_reg <= in_word;
            end
            else
            begin
                head_reg <= in_word;
            end
        end
    end

endmodule

// ==== shared/cfg_loader_pkg.sv ====
package cfg_loader_pkg;

    // Core clock period in nanoseconds (250 MHz).
    localparam int CLK_PERIOD_NS         = 4;

    // Request low to both outputs low, longest time.
    localparam int REQ_TO_LOW_MAX_NS     = 600;
    localparam int REQ_TO_LOW_MAX_CYC    = REQ_TO_LOW_MAX_NS / CLK_PERIOD_NS;

    // Status low pulse width, least and longest time in microseconds.
    localparam int STATUS_LOW_MIN_US     = 268;
    localparam int STATUS_LOW_MAX_US     = 1506;
    localparam int STATUS_HOLD_CYC       = (STATUS_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Load complete high to user mode on the internal timer, in microseconds.
    localparam int INIT_MIN_US           = 175;
    localparam int INIT_MAX_US           = 437;
    localparam int INIT_OSC_CYC          = (INIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Delay before the user start-up clock is enabled: four fastest-legal serial clock periods.
    localparam int SERIAL_CLK_MAX_MHZ    = 125;
    localparam int SERIAL_CLK_PERIOD_NS  = 1000 / SERIAL_CLK_MAX_MHZ;
    localparam int UCLK_DELAY_PERIODS    = 4;
    localparam int UCLK_DELAY_NS         = UCLK_DELAY_PERIODS * SERIAL_CLK_PERIOD_NS;
    localparam int UCLK_DELAY_CYC        = (UCLK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // User start-up clock periods needed before user mode.
    localparam int USER_INIT_PERIODS     = 8576;

    // Default bitstream length in bytes.
    localparam int BITSTREAM_BYTES_DFLT  = 1024;

    // Widths of counters and data.
    localparam int TIMER_W               = 17;
    localparam int BYTE_CNT_W            = 24;
    localparam int BYTE_W                = 8;
    localparam int BIT_CNT_W             = 3;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;

    // Synchroniser lanes and their idle levels.
    localparam int SYNC_REQ              = 0;
    localparam int SYNC_STAT             = 1;
    localparam int SYNC_UCLK             = 2;
    localparam int SYNC_TOG              = 3;
    localparam int SYNC_COUNT            = 4;
    localparam logic [SYNC_COUNT-1:0] SYNC_INIT = 4'h3;

    // Configuration sequence states.
    typedef enum logic [2:0] {
        ST_RESET     = 3'h0,
        ST_WAIT_STAT = 3'h1,
        ST_LOAD      = 3'h2,
        ST_INIT      = 3'h3,
        ST_USER      = 3'h4,
        ST_ERROR     = 3'h5
    } cfg_state_e;

    // One received configuration byte with its end-of-bitstream mark.
    typedef struct packed {
        logic [BYTE_W-1:0] data;
        logic              last;
    } cfg_word_s;

endpackage

// ==== verif/cfg_host_model.sv ====
`timescale 1ns/10ps

module cfg_host_model
#(
    parameter int HALF_NS = 15,
    parameter int WAIT_NS = 2000
)
(
    // Status wire as the host sees it.
    input  wire logic status_wire,
    input  wire logic uclk_run,
    // Pins driven toward the device.
    output logic      config_request_n,
    output logic      serial_load_clock,
    output logic      serial_data,
    output logic      user_init_clock
);
    // The serial clock stands low outside frames.
    initial
    begin
        config_request_n = 1'b1;
        serial_load_clock = 1'b0;
        serial_data = 1'b0;
        user_init_clock = 1'b0;
    end

    // The start-up clock runs at a 40 ns period for as long as the bench asks.
    always #20 user_init_clock = uclk_run ? ~user_init_clock : 1'b0;

    // Pulses the request, then waits on the status wire before any clocking.
    task automatic pulse_request();
        config_request_n = 1'b0;
        #(WAIT_NS);
        config_request_n = 1'b1;
        #(100);
        wait (status_wire === 1'b1);
        #(WAIT_NS);
    endtask

    // Drops the request and leaves it low.
    task automatic drop_request();
        config_request_n = 1'b0;
    endtask

    // Sends one byte, least significant bit first, each bit set up half a period ahead.
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            serial_data = b[i];
            #(HALF_NS);
            serial_load_clock = 1'b1;
            #(HALF_NS);
            serial_load_clock = 1'b0;
        end
        // The line no longer shows the last bit once the frame is over.
        serial_data = ~b[7];
        #(HALF_NS);
    endtask
endmodule

// ==== verif/cfg_seq_chk.sv ====
`timescale 1ns/10ps

module cfg_seq_chk
    import cfg_loader_pkg::*;
#(
    parameter int STATUS_HOLD   = STATUS_HOLD_CYC,
    parameter int INIT_OSC      = INIT_OSC_CYC,
    parameter int USER_PERIODS  = USER_INIT_PERIODS,
    parameter int BITSTREAM_LEN = BITSTREAM_BYTES_DFLT
)
(
    // Watched ports of the loader.
    input wire logic      clk,
    input wire logic      sys_rst,
    input wire logic      config_request_n,
    input wire logic      cfg_state_flag_n_in,
    input wire logic      cfg_state_flag_n_out,
    input wire logic      cfg_state_flag_n_oe,
    input wire logic      serial_load_clock,
    input wire logic      serial_data,
    input wire logic      load_complete,
    input wire logic      user_mode,
    input wire logic      user_clock_option,
    input wire logic      user_init_clock,
    input wire logic      user_init_clock_enable,
    input wire cfg_word_s cfg_word,
    input wire logic      cfg_word_valid,
    input wire logic      cfg_word_ready
);
    localparam int REL_MAX = STATUS_HOLD + 12;
    localparam int INIT_HI = INIT_OSC + 4;

    int         oe_cnt;   // Cycles the status pull has lasted.
    int         word_cnt; // Words handed out since the last request.
    int         uclk_cnt; // Start-up clock rises seen while enabled.
    int         init_cnt; // Cycles from load complete while user mode is still low.
    int         rel_cnt;  // Cycles the status pull has lasted since the request was released.
    logic       rel_arm;  // Request released and status not yet let go.
    logic [1:0] uclk_smp; // Start-up clock samples.

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Measures the status pull, counts words and start-up clock rises, and times release and start-up.
    always_ff @(posedge clk)
    begin
        oe_cnt <= (sys_rst || !cfg_state_flag_n_oe) ? 0 : oe_cnt + 1;
        word_cnt <= (sys_rst || !config_request_n) ? 0 : word_cnt + int'(cfg_word_valid && cfg_word_ready);
        uclk_smp <= {uclk_smp[0], user_init_clock};
        uclk_cnt <= (sys_rst || !user_init_clock_enable) ? 0 : uclk_cnt + int'(uclk_smp == 2'h1);
        rel_arm <= !sys_rst && config_request_n && cfg_state_flag_n_oe && (rel_arm || !$past(config_request_n));
        rel_cnt <= rel_arm ? rel_cnt + 1 : 0;
        init_cnt <= (sys_rst || !load_complete || user_mode) ? 0 : init_cnt + 1;
    end

    req_done_low_a: assert property ($fell(config_request_n) |-> ##[1:150] !load_complete)
        else $error("load complete still high after request");
    req_status_low_a: assert property ($fell(config_request_n) |-> ##[1:150] cfg_state_flag_n_oe)
        else $error("status not pulled low after request");
    status_min_a: assert property ($fell(cfg_state_flag_n_oe) |-> oe_cnt >= STATUS_HOLD - 1)
        else $error("status low pulse too short");
    status_release_a: assert property (rel_cnt <= REL_MAX)
        else $error("status not released after request");
    init_osc_a: assert property ($rose(user_mode) && !user_clock_option |->
        init_cnt >= INIT_OSC && init_cnt <= INIT_HI) else $error("user mode timing wrong");
    uclk_late_a: assert property ($rose(load_complete) && user_clock_option |->
        (!user_init_clock_enable)[*8] ##[1:3] user_init_clock_enable) else $error("start-up clock enable timing wrong");
    uclk_count_a: assert property ($rose(user_mode) && user_clock_option |-> uclk_cnt >= USER_PERIODS)
        else $error("user mode before enough start-up clocks");
    done_count_a: assert property ($rose(load_complete) |-> word_cnt == BITSTREAM_LEN)
        else $error("load complete before whole bitstream");
    last_mark_a: assert property (cfg_word_valid && cfg_word.last |-> word_cnt == BITSTREAM_LEN - 1)
        else $error("end mark on wrong word");
endmodule

bind passive_serial_config_sequence cfg_seq_chk #(.STATUS_HOLD(STATUS_HOLD), .INIT_OSC(INIT_OSC),
    .USER_PERIODS(USER_PERIODS), .BITSTREAM_LEN(BITSTREAM_LEN)) cfg_seq_chk_inst (.clk(clk), .sys_rst(sys_rst),
    .config_request_n(config_request_n), .cfg_state_flag_n_in(cfg_state_flag_n_in),
    .cfg_state_flag_n_out(cfg_state_flag_n_out), .cfg_state_flag_n_oe(cfg_state_flag_n_oe),
    .serial_load_clock(serial_load_clock), .serial_data(serial_data), .load_complete(load_complete),
    .user_mode(user_mode), .user_clock_option(user_clock_option), .user_init_clock(user_init_clock),
    .user_init_clock_enable(user_init_clock_enable), .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid),
    .cfg_word_ready(cfg_word_ready));

// ==== verif/tb.sv ====
`timescale 1ns/10ps

`define CHECK(name, exp, act) \
    begin \
        check_count++; \
        if ((act) !== (exp)) \
        begin \
            err_count++; \
            $display("wrong value %s expected %h seen %h", name, exp, act); \
        end \
    end

module tb
    import cfg_loader_pkg::*;
;
    localparam int LEN = 4;

    // One load: option, consumer stall, bytes and how many of them are sent.
    typedef struct {logic opt; logic stall; logic [39:0] bytes; int n;} row_t;

    logic        clk = 1'b0;     // Core clock.
    logic        sys_rst = 1'b1; // Synchronous reset.
    logic        config_request_n, serial_load_clock, serial_data, user_init_clock;
    logic        status_wire, oe, drv, load_complete, user_mode, uclk_en, valid;
    logic        user_clock_option = 1'b0;
    logic        cfg_word_ready = 1'b0;
    logic        ready_en = 1'b0; // Consumer takes words.
    logic        stall = 1'b0;    // Consumer takes every other cycle.
    logic        uclk_run = 1'b0; // Host runs the start-up clock.
    cfg_word_s   cfg_word;
    cfg_word_s   got[$];          // Words taken by the consumer.
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    row_t        rows[2] = '{'{1'b0, 1'b0, 40'h00_01_A5_FF_00, 4}, '{1'b1, 1'b1, 40'h77_80_FE_5A_C3, 5}};

    always #2 clk = ~clk;

    // The status pin has a pull-up; the device only ever pulls it low.
    assign status_wire = (oe === 1'b1) ? drv : 1'b1;

    passive_serial_config_sequence #(.STATUS_HOLD(20), .INIT_OSC(10), .USER_PERIODS(4), .BITSTREAM_LEN(LEN))
        passive_serial_config_sequence_inst (.clk(clk), .sys_rst(sys_rst), .config_request_n(config_request_n),
        .cfg_state_flag_n_in(status_wire), .cfg_state_flag_n_out(drv), .cfg_state_flag_n_oe(oe),
        .serial_load_clock(serial_load_clock), .serial_data(serial_data), .load_complete(load_complete),
        .user_mode(user_mode), .user_clock_option(user_clock_option), .user_init_clock(user_init_clock),
        .user_init_clock_enable(uclk_en), .cfg_word(cfg_word), .cfg_word_valid(valid),
        .cfg_word_ready(cfg_word_ready));

    cfg_host_model cfg_host_model_inst (.status_wire(status_wire), .uclk_run(uclk_run),
        .config_request_n(config_request_n), .serial_load_clock(serial_load_clock),
        .serial_data(serial_data), .user_init_clock(user_init_clock));

    // The consumer drives ready on the falling edge and logs each taken word.
    always @(negedge clk) cfg_word_ready <= ready_en && (!stall || !cfg_word_ready);
    always @(posedge clk)
    begin
        if (valid && cfg_word_ready)
            got.push_back(cfg_word);
    end

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One whole load from request to user mode, with every word compared.
    task automatic run_row(input row_t rw);
        @(negedge clk);
        user_clock_option = rw.opt;
        stall = rw.stall;
        ready_en = 1'b1;
        uclk_run = rw.opt;
        cfg_host_model_inst.pulse_request();
        got.delete();
        for (int i = 0; i < rw.n; i++)
            cfg_host_model_inst.send_byte(rw.bytes[8*i +: 8]);
        wait (load_complete === 1'b1);
        `CHECK("word count", LEN, got.size())
        for (int i = 0; i < LEN; i++)
            `CHECK("word", {rw.bytes[8*i +: 8], i == LEN - 1}, got[i])
        wait (user_mode === 1'b1);
        @(negedge clk);
        `CHECK("start-up enable", 1'b0, uclk_en)
        `CHECK("load complete", 1'b1, load_complete)
        uclk_run = 1'b0;
    endtask

    // A hang is cut short well past the expected run length.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            err_count++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        `CHECK("status pull", 1'b1, oe)
        `CHECK("load complete", 1'b0, load_complete)
        `CHECK("user mode", 1'b0, user_mode)
        `CHECK("word valid", 1'b0, valid)
        foreach (rows[r])
            run_row(rows[r]);
        // Overrun: the consumer stalls and a third byte finds the buffer full.
        @(negedge clk);
        ready_en = 1'b0;
        cfg_host_model_inst.pulse_request();
        for (int i = 0; i < 3; i++)
            cfg_host_model_inst.send_byte(8'h3C);
        repeat (40) @(negedge clk);
        `CHECK("load complete", 1'b0, load_complete)
        `CHECK("status pull", 1'b1, oe)
        run_row(rows[0]);
        // A new request from user mode must clear both outputs in time.
        cfg_host_model_inst.drop_request();
        repeat (150) @(negedge clk);
        `CHECK("load complete", 1'b0, load_complete)
        `CHECK("status pull", 1'b1, oe)
        end_of_test();
    end
endmodule
